// >>> verilog/sram_fifo_pkg.sv
// shared constants, width codes and helpers for the embedded memory/fifo block
package sram_fifo_pkg;

  // port width codes
  typedef enum logic [2:0] {
    width_18 = 3'b000,
    width_9  = 3'b001,
    width_4  = 3'b010,
    width_2  = 3'b011,
    width_1  = 3'b100
  } width_t;

  // array geometry: 256 rows of 18 bits, 4,608 bits in all
  localparam int unsigned row_count = 256;
  localparam int unsigned row_bits = 18;
  localparam int unsigned total_bits = row_count * row_bits;
  localparam int unsigned addr_bits = 12;
  localparam int unsigned count_bits = 13;
  localparam int unsigned row_addr_bits = 8;

  // reset values and the 256-word fifo depth at 18 wide
  localparam logic [11:0] ptr_reset = 12'h000;
  localparam logic [12:0] count_reset = 13'h0000;
  localparam logic [17:0] data_reset = 18'h00000;
  localparam logic [12:0] base_depth = 13'h0100;

  // log2 of words per row for each width code
  function automatic logic [2:0] width_shift(input width_t w);
    case (w)
      width_18: width_shift = 3'h0;
      width_9:  width_shift = 3'h1;
      width_4:  width_shift = 3'h2;
      width_2:  width_shift = 3'h3;
      width_1:  width_shift = 3'h4;
      default:  width_shift = 3'h0;
    endcase
  endfunction

  // data bits per word for each width code
  function automatic logic [4:0] width_bits(input width_t w);
    case (w)
      width_18: width_bits = 5'h12;
      width_9:  width_bits = 5'h09;
      width_4:  width_bits = 5'h04;
      width_2:  width_bits = 5'h02;
      width_1:  width_bits = 5'h01;
      default:  width_bits = 5'h12;
    endcase
  endfunction

endpackage

// >>> verilog/mem_port_if.sv
// write and read port bundle between the control unit and the storage array
`timescale 1ns/10ps
`default_nettype none
interface mem_port_if;
  // write side
  logic we;
  logic [11:0] waddr;
  logic [17:0] wdata;
  sram_fifo_pkg::width_t wwidth;
  // read side
  logic re;
  logic [11:0] raddr;
  sram_fifo_pkg::width_t rwidth;
  logic [17:0] rdata;

  modport ctrl (output we, output waddr, output wdata, output wwidth,
                output re, output raddr, output rwidth, input rdata);
  modport array (input we, input waddr, input wdata, input wwidth,
                 input re, input raddr, input rwidth, output rdata);
endinterface
`default_nettype wire

// >>> verilog/sram_array.sv
// 4,608-bit storage array with independently sized write and read ports
`timescale 1ns/10ps
`default_nettype none
module sram_array (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // port bundle
  mem_port_if.array port
);

  logic [17:0] mem_q [sram_fifo_pkg::row_count];
  logic [17:0] rdata_q;

  // write lane decode: row, bit offset and lane mask
  wire [2:0] w_shift = sram_fifo_pkg::width_shift(port.wwidth);
  wire [4:0] w_bits = sram_fifo_pkg::width_bits(port.wwidth);
  wire [11:0] w_row = port.waddr >> w_shift;
  wire [11:0] w_lane = port.waddr & ((12'h001 << w_shift) - 12'h001);
  wire [4:0] w_off = 5'(w_lane * w_bits);
  wire [17:0] w_low = (18'h00001 << w_bits) - 18'h00001; // all ones at 18
  wire [17:0] w_mask = 18'(w_low << w_off);
  wire [17:0] w_data = 18'((port.wdata & w_low) << w_off);
  wire w_hit = port.we && (w_row < 12'(sram_fifo_pkg::row_count));

  // read lane decode
  wire [2:0] r_shift = sram_fifo_pkg::width_shift(port.rwidth);
  wire [4:0] r_bits = sram_fifo_pkg::width_bits(port.rwidth);
  wire [11:0] r_row = port.raddr >> r_shift;
  wire [11:0] r_lane = port.raddr & ((12'h001 << r_shift) - 12'h001);
  wire [4:0] r_off = 5'(r_lane * r_bits);
  wire [17:0] r_low = (18'h00001 << r_bits) - 18'h00001;
  wire r_hit = port.re && (r_row < 12'(sram_fifo_pkg::row_count));
  wire [17:0] r_word = (mem_q[r_row[7:0]] >> r_off) & r_low;

  // masked row write, only the addressed lane changes
  always_ff @(posedge ref_clk)
  begin
    if (w_hit)
      mem_q[w_row[7:0]] <= (mem_q[w_row[7:0]] & ~w_mask) | w_data;
  end

  // registered read, data one cycle after the read request
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      rdata_q <= sram_fifo_pkg::data_reset;
    else if (r_hit)
      rdata_q <= r_word;
  end

  assign port.rdata = rdata_q;

endmodule
`default_nettype wire

// >>> verilog/sram_fifo_block.sv
// embedded memory block with its own fifo control unit
// Overview of operation
// - array always holds 4,608 bits
// - five organizations from 256x18 to 4kx1
// - independent read and write ports, separate widths in ram mode (fifo reads use the write width)
// - test port preloads rows in rom mode
// - built-in fifo control, no fabric logic
// - fifo width and depth chosen by mode
// - empty, full, almost flags with thresholds
// - counters generate read and write pointers
// - block select lets blocks be chained
//
`timescale 1ns/10ps
`default_nettype none
module sram_fifo_block (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // configuration
  input wire logic fifo_mode,
  input wire sram_fifo_pkg::width_t wr_width,
  input wire sram_fifo_pkg::width_t rd_width,
  input wire logic [12:0] almost_full_thr,
  input wire logic [12:0] almost_empty_thr,
  input wire logic rom_mode,
  input wire logic block_sel,
  // write port
  input wire logic wr_en,
  input wire logic [11:0] wr_addr,
  input wire logic [17:0] wr_data,
  // read port
  input wire logic rd_en,
  input wire logic [11:0] rd_addr,
  output logic [17:0] rd_data,
  output logic rd_valid,
  // preload from the user test port macro
  input wire logic preload_we,
  input wire logic [7:0] preload_row,
  input wire logic [17:0] preload_data,
  // fifo status
  output logic empty,
  output logic full,
  output logic almost_empty_flag,
  output logic almost_full_flag,
  output logic [11:0] wr_ptr,
  output logic [11:0] rd_ptr
);

  mem_port_if port ();

  logic [11:0] wr_ptr_q;
  logic [11:0] wr_ptr_d;
  logic [11:0] rd_ptr_q;
  logic [11:0] rd_ptr_d;
  logic [12:0] count_q;
  logic [12:0] count_d;
  logic empty_q;
  logic full_q;
  logic almost_empty_flag_q;
  logic almost_full_flag_q;
  logic rd_valid_q;

  ////////////////////////////////////////////////////////////////////////////////
  // fifo geometry follows the write width code
  wire [2:0] fifo_shift = sram_fifo_pkg::width_shift(wr_width);
  wire [12:0] fifo_depth = 13'(sram_fifo_pkg::base_depth << fifo_shift);
  wire [11:0] ptr_mask = 12'(fifo_depth - 13'h0001);

  // accepted requests; block select gates every user access
  wire fifo_wr = fifo_mode && wr_en && block_sel && !rom_mode && !full_q;
  wire fifo_rd = fifo_mode && rd_en && block_sel && !empty_q;
  wire ram_wr = !fifo_mode && wr_en && block_sel && !rom_mode;
  wire ram_rd = !fifo_mode && rd_en && block_sel;
  wire user_wr = (fifo_wr || ram_wr) && !preload_we;
  wire any_rd = fifo_rd || ram_rd;

  // pointer and occupancy next values
  assign wr_ptr_d = (fifo_wr && !preload_we) ? ((wr_ptr_q + 12'h001) & ptr_mask) : wr_ptr_q;
  assign rd_ptr_d = fifo_rd ? ((rd_ptr_q + 12'h001) & ptr_mask) : rd_ptr_q;
  assign count_d = count_q + {12'h000, fifo_wr && !preload_we} - {12'h000, fifo_rd};

  ////////////////////////////////////////////////////////////////////////////////
  // array port steering: preload wins and writes whole 18-bit rows
  assign port.we = preload_we || user_wr;
  assign port.waddr = preload_we ? {4'h0, preload_row} : (fifo_mode ? wr_ptr_q : wr_addr);
  assign port.wdata = preload_we ? preload_data : wr_data;
  assign port.wwidth = preload_we ? sram_fifo_pkg::width_18 : wr_width;
  assign port.re = any_rd;
  assign port.raddr = fifo_mode ? rd_ptr_q : rd_addr;
  assign port.rwidth = fifo_mode ? wr_width : rd_width;

  sram_array u_array (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .port(port)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // pointers and occupancy
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n || !fifo_mode)
    begin
      wr_ptr_q <= sram_fifo_pkg::ptr_reset;
      rd_ptr_q <= sram_fifo_pkg::ptr_reset;
      count_q <= sram_fifo_pkg::count_reset;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
    end
  end

  // status flags registered from next occupancy
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n || !fifo_mode)
    begin
      empty_q <= 1'b1;
      full_q <= 1'b0;
      almost_empty_flag_q <= 1'b1;
      almost_full_flag_q <= 1'b0;
    end
    else
    begin
      empty_q <= (count_d == 13'h0000);
      full_q <= (count_d >= fifo_depth);
      almost_empty_flag_q <= (count_d <= almost_empty_thr);
      almost_full_flag_q <= (count_d >= almost_full_thr);
    end
  end

  // read data valid one cycle after an accepted read
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      rd_valid_q <= 1'b0;
    else
      rd_valid_q <= any_rd;
  end

  assign rd_data = port.rdata;
  assign rd_valid = rd_valid_q;
  assign empty = empty_q;
  assign full = full_q;
  assign almost_empty_flag = almost_empty_flag_q;
  assign almost_full_flag = almost_full_flag_q;
  assign wr_ptr = wr_ptr_q;
  assign rd_ptr = rd_ptr_q;

endmodule
`default_nettype wire

// >>> bench/sram_fifo_block_sva.sv
// port assertions for the memory/fifo block
`timescale 1ns/10ps
`default_nettype none
module sram_fifo_block_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // requests
  input wire logic fifo_mode,
  input wire logic rom_mode,
  input wire logic block_sel,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic preload_we,
  // status
  input wire logic rd_valid,
  input wire logic empty,
  input wire logic full,
  input wire logic almost_full_flag,
  input wire logic [11:0] wr_ptr,
  input wire logic [11:0] rd_ptr
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // accepted fifo requests
  sequence s_rd_taken;
    fifo_mode && block_sel && rd_en && !empty;
  endsequence
  sequence s_wr_taken;
    fifo_mode && block_sel && wr_en && !rom_mode && !preload_we && !full && !rd_en;
  endsequence
  chk_read_answer: assert property (s_rd_taken |=> rd_valid)
    else $error("accepted read gave no data");
  chk_read_empty: assert property (fifo_mode && empty && rd_en |=> !rd_valid && $stable(rd_ptr))
    else $error("read from empty fifo taken");
  chk_write_full: assert property (fifo_mode && full && wr_en && !rd_en |=> full && $stable(wr_ptr))
    else $error("write into full fifo taken");
  chk_write_moves: assert property (s_wr_taken |=> !empty && wr_ptr != $past(wr_ptr))
    else $error("accepted write lost");
  chk_valid_cause: assert property (rd_valid |-> $past(rd_en && block_sel))
    else $error("read data without request");
  chk_full_almost: assert property (full |-> almost_full_flag && !empty)
    else $error("full without almost full");
  chk_ram_idle: assert property (!fifo_mode |=> empty && wr_ptr == 12'h000 && rd_ptr == 12'h000)
    else $error("fifo state kept in ram mode");
  chk_reset_clear: assert property (disable iff (1'b0) !reset_n |=> empty && !full && wr_ptr == 12'h000)
    else $error("reset did not clear fifo");
endmodule
bind sram_fifo_block sram_fifo_block_sva sram_fifo_block_sva_inst (.ref_clk, .reset_n, .fifo_mode,
  .rom_mode, .block_sel, .wr_en, .rd_en, .preload_we, .rd_valid, .empty, .full, .almost_full_flag,
  .wr_ptr, .rd_ptr);
`default_nettype wire

// >>> bench/fabric_reader.sv
// fabric-side reader that drains the fifo while asked to
`timescale 1ns/10ps
`default_nettype none
module fabric_reader (
  // clock and control
  input wire logic ref_clk,
  input wire logic drain,
  input wire logic empty,
  // read request
  output var logic rd_en = 1'b0
);
  // registered request: a stale request after the last word is refused
  always_ff @(posedge ref_clk)
  begin
    rd_en <= drain && !empty;
  end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the memory/fifo block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic ref_clk, reset_n, fifo_mode, rom_mode, block_sel, wr_en, tb_rd, fab_rd, drain, preload_we;
  logic rd_valid, empty, full, ae, af;
  sram_fifo_pkg::width_t wr_width, rd_width;
  logic [11:0] wr_addr, rd_addr, wr_ptr, rd_ptr;
  logic [17:0] wr_data, rd_data, pre_data;
  logic [7:0] pre_row;
  int fails = 0, compares = 0, nrd = 0;
  int bw[5] = '{18, 9, 4, 2, 1};
  sram_fifo_block sram_fifo_block_inst (.ref_clk, .reset_n, .fifo_mode, .wr_width, .rd_width,
    .almost_full_thr(13'h0004), .almost_empty_thr(13'h0001), .rom_mode, .block_sel, .wr_en,
    .wr_addr, .wr_data, .rd_en(tb_rd | fab_rd), .rd_addr, .rd_data, .rd_valid, .preload_we,
    .preload_row(pre_row), .preload_data(pre_data), .empty, .full, .almost_empty_flag(ae),
    .almost_full_flag(af), .wr_ptr, .rd_ptr);
  fabric_reader fabric_reader_inst (.ref_clk, .drain, .empty, .rd_en(fab_rd));
  ////////////////////////////////////////////////////////////////
  // compare, verdict and bus tasks
  task automatic chk(input logic [27:0] got, input logic [27:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [17:0] d);
    @(posedge ref_clk);
    wr_en <= 1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [17:0] e, input logic v);
    @(posedge ref_clk);
    tb_rd <= 1;
    rd_addr <= a;
    @(posedge ref_clk);
    tb_rd <= 0;
    @(negedge ref_clk);
    chk({9'h0, rd_valid, rd_data}, {9'h0, v, e});
  endtask
  ////////////////////////////////////////////////////////////////
  // clock, fifo order monitor and watchdog
  initial
  begin
    ref_clk = 0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    if (rd_valid === 1'b1 && fifo_mode)
    begin
      chk(28'(rd_data), 28'(nrd));
      nrd++;
    end
  end
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////
  // scenarios
  initial
  begin
    int n;
    {reset_n, fifo_mode, rom_mode, wr_en, tb_rd, drain, preload_we} = '0;
    block_sel = 1;
    wr_width = sram_fifo_pkg::width_18;
    rd_width = sram_fifo_pkg::width_18;
    {wr_addr, rd_addr, wr_data, pre_data, pre_row} = '0;
    repeat (16) @(posedge ref_clk);
    chk({empty, full, ae, af, wr_ptr}, {4'ha, 12'h000});
    reset_n <= 1;
    fifo_mode <= 1;
    // fill 256 words, the last attempt lands on a full fifo
    for (int i = 0; i < 257; i++)
    begin
      @(posedge ref_clk);
      wr_en <= 1;
      wr_data <= 18'(i);
    end
    @(posedge ref_clk);
    wr_en <= 0;
    @(negedge ref_clk);
    chk({empty, full, af}, 3'h3);
    drain <= 1;
    n = 0;
    while (nrd < 256 && n++ < 600) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
    drain <= 0;
    @(negedge ref_clk);
    chk({empty, full, ae, 25'(nrd)}, {3'h5, 25'h100});
    // ram mode: write 18 wide, read lane 0 at every width
    fifo_mode <= 0;
    wr(12'h005, 18'h2a5c3);
    for (int k = 0; k < 5; k++)
    begin
      rd_width <= sram_fifo_pkg::width_t'(3'(k));
      rd(12'(12'h005 << k), 18'h2a5c3 & ((18'h1 << bw[k]) - 18'h1), 1);
    end
    // preload a row, then a blocked user write in rom mode
    @(posedge ref_clk);
    preload_we <= 1;
    pre_row <= 8'h09;
    pre_data <= 18'h0beef;
    rd_width <= sram_fifo_pkg::width_18;
    @(posedge ref_clk);
    preload_we <= 0;
    rom_mode <= 1;
    wr(12'h009, 18'h11111);
    rd(12'h009, 18'h0beef, 1);
    block_sel <= 0;
    rd(12'h009, 18'h0beef, 0);
    // fifo at 9 wide: two words, thresholds and read pointer
    block_sel <= 1;
    rom_mode <= 0;
    fifo_mode <= 1;
    wr_width <= sram_fifo_pkg::width_9;
    wr(12'h000, 18'h00100);
    wr(12'h000, 18'h00101);
    @(negedge ref_clk);
    chk({empty, full, ae, af, wr_ptr, rd_ptr}, {4'h0, 12'h002, 12'h000});
    drain <= 1;
    n = 0;
    while (nrd < 258 && n++ < 60) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
    drain <= 0;
    @(negedge ref_clk);
    chk({empty, ae, rd_ptr, 14'(nrd)}, {2'h3, 12'h002, 14'h0102});
    close_out();
  end
endmodule
`default_nettype wire
